// [pkg/i2c_host_map.svh]
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz aclk
// Notes:   definitions only
`ifndef I2C_HOST_MAP_SVH
`define I2C_HOST_MAP_SVH
`define REG_CTRL       8'h00
`define REG_ADDR       8'h04
`define REG_WDATA      8'h08
`define REG_RDATA      8'h0c
`define REG_STATUS     8'h10
`define REG_DEV        8'h14
`define REG_PAYLOAD    8'h18
`define CTRL_GO        0
`define CTRL_DEVRST    1
`define CTRL_CFG_LSB   2
`define CTRL_CFG_MSB   10
`define STAT_BUSY      0
`define STAT_READY     1
`define STAT_NACK      2
`define STAT_REFUSED   3
`define RESP_OK        2'h0
`define RESP_SLVERR    2'h2
`define DEV_ADDR_RST   7'h58
`define PAGE_OFF_ONE   8'hfc
`define PAGE_OFF_TWO   16'hfffc
`define OFF_ONE_LAST   9'h0ff
`define CLK_NS         10
`define QTR_100K_NS    2500
`define QTR_400K_NS    625
`define QTR_1M_NS      250
`define QTR_100K_CYC   ((`QTR_100K_NS + `CLK_NS - 1) / `CLK_NS)
`define QTR_400K_CYC   ((`QTR_400K_NS + `CLK_NS - 1) / `CLK_NS)
`define QTR_1M_CYC     ((`QTR_1M_NS + `CLK_NS - 1) / `CLK_NS)
`define RST_LOW_NS     20
`define RST_LOW_CYC    ((`RST_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define WAIT_NOEE_MS   15
`define WAIT_NODEV_MS  150
`define WAIT_NOEE_CYC  (`WAIT_NOEE_MS * 1000000 / `CLK_NS)
`define WAIT_NODEV_CYC (`WAIT_NODEV_MS * 1000000 / `CLK_NS)
`define EE_DIV         256
`define EE_MUL         2342
`define EE_ADD         2250
`define EE_MARGIN_PCT  115
`define PCT_DIV        100
`endif

// [pkg/i2c_host_pkg.sv]
// Purpose: types of the i2c host controller
// Assumes: constants live in i2c_host_map.svh
// Notes:   the whole state is one packed struct
package i2c_host_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_RST = 3'h1, ST_WAIT = 3'h2, ST_START = 3'h3,
    ST_TX = 3'h4, ST_RX = 3'h5, ST_STOP = 3'h6
  } state_t;
  typedef enum logic [2:0] {
    SEQ_DEVW = 3'h0, SEQ_OFFH = 3'h1, SEQ_OFFL = 3'h2,
    SEQ_DATA = 3'h3, SEQ_DEVR = 3'h4, SEQ_RDAT = 3'h5
  } seq_t;
  typedef struct packed {
    logic [1:0] wsel;
    logic [1:0] len_m1;
    logic [1:0] rate;
    logic       two_byte_offset_mode;
    logic       page;
    logic       rd;
  } cfg_t;
  typedef struct packed {
    logic scl_i;
    logic sda_i;
  } link_in_t;
  typedef struct packed {
    logic master_reset_low;
    logic bus_addr_strap_bit0;
    logic bus_addr_strap_bit1;
    logic bus_addr_gpio_bit2;
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } link_out_t;
  typedef struct packed {
    state_t      st;
    seq_t        seq;
    logic [1:0]  ph;
    logic [3:0]  bitn;
    logic [1:0]  dcnt;
    logic [7:0]  sh;
    logic [7:0]  qdiv;
    logic [31:0] cnt;
    logic        scl_oe;
    logic        sda_oe;
    logic        mrst_low;
    logic        ready;
    logic        nack;
    logic        refused;
    cfg_t        cfg;
    logic [15:0] addr;
    logic [31:0] wbuf;
    logic [31:0] rdat;
    logic [6:0]  dev;
    logic [15:0] payload;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rd_bus;
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic        scl_f;
    logic        sda_f;
  } host_state_t;
endpackage

// [hdl/i2c_host.sv]
// Purpose: i2c host that resets a timing device, waits, then reads and writes its registers
// Assumes: software drives it over AXI4-Lite; the device is an i2c slave
// Notes:   open-drain pins; oe high pulls the line low
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "i2c_host_map.svh"

// Overview of operation
// - no access within 15ms without eeprom load
// - wait 150ms when eeprom absent
// - eeprom present: wait from payload formula
// - port options change within one burst
// - straps set address bits, held static
// - page register at 0xFC, one burst
// - two byte: page at 0xFFFC, four bytes
// - multi-byte registers in one burst
// - one byte bursts stop at 0xFF
// - read: offset, repeated start, read address
module i2c_host #(
  parameter int WAIT_NOEE_CYC  = `WAIT_NOEE_CYC,
  parameter int WAIT_NODEV_CYC = `WAIT_NODEV_CYC
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [7:0]             awaddr,
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [7:0]             araddr,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  input  wire i2c_host_pkg::link_in_t link_i,
  output var i2c_host_pkg::link_out_t link_o
);

  i2c_host_pkg::host_state_t q_r;
  i2c_host_pkg::host_state_t q_nxt;
  logic                      tick;
  logic                      idle;
  logic [31:0]               m;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] qtr_cyc(input logic [1:0] rate);
    unique case (rate)
      2'h0: qtr_cyc = 8'(`QTR_100K_CYC);
      2'h1: qtr_cyc = 8'(`QTR_400K_CYC);
      default: qtr_cyc = 8'(`QTR_1M_CYC);
    endcase
  endfunction

  // formula is floored then padded by one cycle so it never runs short
  function automatic logic [31:0] wait_cyc(input i2c_host_pkg::cfg_t c, input logic [15:0] pay);
    logic [47:0] u;
    u = 48'(pay) * 48'(`EE_MUL) / 48'(`EE_DIV) + 48'(`EE_ADD);
    u = u * 48'({qtr_cyc(c.rate), 2'b00}) * 48'(`EE_MARGIN_PCT) / 48'(`PCT_DIV);
    unique case (c.wsel)
      2'h0: wait_cyc = 32'(WAIT_NOEE_CYC);
      2'h1: wait_cyc = 32'(WAIT_NODEV_CYC);
      default: wait_cyc = u[31:0] + 32'h0000_0001;
    endcase
  endfunction

  function automatic logic [1:0] len_of(input i2c_host_pkg::cfg_t c);
    len_of = c.page ? 2'h3 : c.len_m1;
  endfunction

  function automatic logic [15:0] off_of(input i2c_host_pkg::host_state_t x);
    if (!x.cfg.page)
      off_of = x.addr;
    else if (x.cfg.two_byte_offset_mode)
      off_of = `PAGE_OFF_TWO;
    else
      off_of = {8'h00, `PAGE_OFF_ONE};
  endfunction

  function automatic logic [7:0] tx_byte(input i2c_host_pkg::host_state_t x);
    unique case (x.seq)
      i2c_host_pkg::SEQ_DEVW: tx_byte = {x.dev, 1'b0};
      i2c_host_pkg::SEQ_OFFH: tx_byte = 8'(off_of(x) >> 8);
      i2c_host_pkg::SEQ_OFFL: tx_byte = 8'(off_of(x));
      i2c_host_pkg::SEQ_DATA: tx_byte = x.wbuf[{x.dcnt, 3'b000} +: 8];
      i2c_host_pkg::SEQ_DEVR: tx_byte = {x.dev, 1'b1};
      default: tx_byte = 8'h00;
    endcase
  endfunction

  // a one byte burst may not wrap past the end of its page
  function automatic logic over_page(input i2c_host_pkg::host_state_t x);
    over_page = !x.cfg.two_byte_offset_mode && !x.cfg.page
             && ({1'b0, x.addr[7:0]} + {7'h00, x.cfg.len_m1} > `OFF_ONE_LAST);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    merge = r;
  endfunction

  assign tick    = (q_r.qdiv == 8'h00);
  assign idle    = (q_r.st == i2c_host_pkg::ST_IDLE);
  assign awready = !q_r.aw_got && !q_r.bvalid;
  assign wready  = !q_r.w_got && !q_r.bvalid;
  assign arready = !q_r.rvalid;
  assign bvalid  = q_r.bvalid;
  assign bresp   = q_r.bresp;
  assign rvalid  = q_r.rvalid;
  assign rdata   = q_r.rd_bus;
  assign rresp   = q_r.rresp;

  always_comb
  begin
    link_o                     = '0;
    link_o.master_reset_low    = q_r.mrst_low;
    link_o.bus_addr_strap_bit0 = q_r.dev[0];
    link_o.bus_addr_strap_bit1 = q_r.dev[1];
    link_o.bus_addr_gpio_bit2  = q_r.dev[2];
    link_o.scl_oe              = q_r.scl_oe;
    link_o.sda_oe              = q_r.sda_oe;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    q_nxt = q_r;
    m     = 32'h0000_0000;
    q_nxt.scl_s = {q_r.scl_s[1:0], link_i.scl_i};
    q_nxt.sda_s = {q_r.sda_s[1:0], link_i.sda_i};
    if (q_r.scl_s[1] == q_r.scl_s[2])
      q_nxt.scl_f = q_r.scl_s[2];
    if (q_r.sda_s[1] == q_r.sda_s[2])
      q_nxt.sda_f = q_r.sda_s[2];
    q_nxt.qdiv = tick ? qtr_cyc(q_r.cfg.rate) - 8'h01 : q_r.qdiv - 8'h01;

    if (awvalid && awready)
    begin
      q_nxt.aw_got = 1'b1;
      q_nxt.awa    = awaddr;
    end
    if (wvalid && wready)
    begin
      q_nxt.w_got = 1'b1;
      q_nxt.wd    = wdata;
      q_nxt.ws    = wstrb;
    end
    if (q_r.bvalid && bready)
      q_nxt.bvalid = 1'b0;
    if (q_r.aw_got && q_r.w_got)
    begin
      q_nxt.aw_got = 1'b0;
      q_nxt.w_got  = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp  = `RESP_OK;
      unique case (q_r.awa)
        `REG_CTRL:
        begin
          m = merge({21'h00_0000, q_r.cfg, 2'b00}, q_r.wd, q_r.ws);
          if (!idle)
            q_nxt.refused = 1'b1;
          else
          begin
            q_nxt.cfg = m[`CTRL_CFG_MSB:`CTRL_CFG_LSB];
            if (m[`CTRL_DEVRST])
            begin
              q_nxt.st       = i2c_host_pkg::ST_RST;
              q_nxt.mrst_low = 1'b0;
              q_nxt.ready    = 1'b0;
              q_nxt.cnt      = 32'(`RST_LOW_CYC - 1);
            end
            else if (m[`CTRL_GO])
            begin
              if (!q_r.ready || over_page(q_nxt))
                q_nxt.refused = 1'b1;
              else
              begin
                q_nxt.st   = i2c_host_pkg::ST_START;
                q_nxt.seq  = i2c_host_pkg::SEQ_DEVW;
                q_nxt.ph   = 2'h0;
                q_nxt.dcnt = 2'h0;
              end
            end
          end
        end
        `REG_ADDR: q_nxt.addr = 16'(merge({16'h0000, q_r.addr}, q_r.wd, q_r.ws));
        `REG_WDATA: q_nxt.wbuf = merge(q_r.wbuf, q_r.wd, q_r.ws);
        `REG_PAYLOAD: q_nxt.payload = 16'(merge({16'h0000, q_r.payload}, q_r.wd, q_r.ws));
        `REG_DEV:
          // straps feed the device address pins, so they only move between transfers
          if (idle)
            q_nxt.dev = 7'(merge({25'h000_0000, q_r.dev}, q_r.wd, q_r.ws));
          else
            q_nxt.refused = 1'b1;
        `REG_STATUS:
        begin
          m = merge(32'h0000_0000, q_r.wd, q_r.ws);
          if (m[`STAT_NACK])
            q_nxt.nack = 1'b0;
          if (m[`STAT_REFUSED])
            q_nxt.refused = 1'b0;
        end
        default: q_nxt.bresp = `RESP_SLVERR;
      endcase
    end

    if (q_r.rvalid && rready)
      q_nxt.rvalid = 1'b0;
    if (arvalid && arready)
    begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp  = `RESP_OK;
      unique case (araddr)
        `REG_CTRL: q_nxt.rd_bus = {21'h00_0000, q_r.cfg, 2'b00};
        `REG_ADDR: q_nxt.rd_bus = {16'h0000, q_r.addr};
        `REG_WDATA: q_nxt.rd_bus = q_r.wbuf;
        `REG_RDATA: q_nxt.rd_bus = q_r.rdat;
        `REG_STATUS: q_nxt.rd_bus = {28'h000_0000, q_r.refused, q_r.nack, q_r.ready, !idle};
        `REG_DEV: q_nxt.rd_bus = {25'h000_0000, q_r.dev};
        `REG_PAYLOAD: q_nxt.rd_bus = {16'h0000, q_r.payload};
        default:
        begin
          q_nxt.rd_bus = 32'h0000_0000;
          q_nxt.rresp  = `RESP_SLVERR;
        end
      endcase
    end

    // bus phases: 0 set sda, 1 release scl, 2 wait scl high, then sample (start/stop: move sda), 3 pull scl low (stop: go idle instead)
    unique case (q_r.st)
      i2c_host_pkg::ST_IDLE: q_nxt.sda_oe = 1'b0;
      i2c_host_pkg::ST_RST:
        if (q_r.cnt == 32'h0000_0000)
        begin
          q_nxt.mrst_low = 1'b1;
          q_nxt.st       = i2c_host_pkg::ST_WAIT;
          q_nxt.cnt      = wait_cyc(q_r.cfg, q_r.payload) - 32'h0000_0001;
        end
        else
          q_nxt.cnt = q_r.cnt - 32'h0000_0001;
      i2c_host_pkg::ST_WAIT:
        if (q_r.cnt == 32'h0000_0000)
        begin
          q_nxt.ready = 1'b1;
          q_nxt.st    = i2c_host_pkg::ST_IDLE;
        end
        else
          q_nxt.cnt = q_r.cnt - 32'h0000_0001;
      i2c_host_pkg::ST_START:
        if (tick)
        begin
          q_nxt.ph = q_r.ph + 2'h1;
          unique case (q_r.ph)
            2'h0: q_nxt.sda_oe = 1'b0;
            2'h1: q_nxt.scl_oe = 1'b0;
            2'h2:
              if (q_r.scl_f)
                q_nxt.sda_oe = 1'b1;
              else
                q_nxt.ph = q_r.ph;
            2'h3:
            begin
              q_nxt.scl_oe = 1'b1;
              q_nxt.st     = i2c_host_pkg::ST_TX;
              q_nxt.bitn   = 4'h0;
              q_nxt.sh     = tx_byte(q_r);
            end
          endcase
        end
      i2c_host_pkg::ST_TX:
        if (tick)
        begin
          q_nxt.ph = q_r.ph + 2'h1;
          unique case (q_r.ph)
            2'h0: q_nxt.sda_oe = (q_r.bitn != 4'h8) && !q_r.sh[7];
            2'h1: q_nxt.scl_oe = 1'b0;
            2'h2:
              if (!q_r.scl_f)
                q_nxt.ph = q_r.ph;
              else if (q_r.bitn == 4'h8)
                q_nxt.sh[0] = q_r.sda_f;
            2'h3:
            begin
              q_nxt.scl_oe = 1'b1;
              q_nxt.bitn   = q_r.bitn + 4'h1;
              q_nxt.sh     = {q_r.sh[6:0], 1'b0};
              if (q_r.bitn == 4'h8)
              begin
                q_nxt.bitn = 4'h0;
                if (q_r.sh[0])
                begin
                  q_nxt.nack = 1'b1;
                  q_nxt.st   = i2c_host_pkg::ST_STOP;
                end
                else
                begin
                  unique case (q_r.seq)
                    i2c_host_pkg::SEQ_DEVW:
                      q_nxt.seq = q_r.cfg.two_byte_offset_mode ? i2c_host_pkg::SEQ_OFFH : i2c_host_pkg::SEQ_OFFL;
                    i2c_host_pkg::SEQ_OFFH: q_nxt.seq = i2c_host_pkg::SEQ_OFFL;
                    i2c_host_pkg::SEQ_OFFL:
                      // a read keeps the bus: repeated start, no stop
                      if (q_r.cfg.rd && !q_r.cfg.page)
                      begin
                        q_nxt.seq = i2c_host_pkg::SEQ_DEVR;
                        q_nxt.st  = i2c_host_pkg::ST_START;
                      end
                      else
                        q_nxt.seq = i2c_host_pkg::SEQ_DATA;
                    i2c_host_pkg::SEQ_DATA:
                      // the whole register goes in one burst
                      if (q_r.dcnt == len_of(q_r.cfg))
                        q_nxt.st = i2c_host_pkg::ST_STOP;
                      else
                        q_nxt.dcnt = q_r.dcnt + 2'h1;
                    i2c_host_pkg::SEQ_DEVR:
                    begin
                      q_nxt.seq = i2c_host_pkg::SEQ_RDAT;
                      q_nxt.st  = i2c_host_pkg::ST_RX;
                    end
                    default: q_nxt.st = i2c_host_pkg::ST_STOP;
                  endcase
                  q_nxt.sh = tx_byte(q_nxt);
                end
              end
            end
          endcase
        end
      i2c_host_pkg::ST_RX:
        if (tick)
        begin
          q_nxt.ph = q_r.ph + 2'h1;
          unique case (q_r.ph)
            2'h0: q_nxt.sda_oe = (q_r.bitn == 4'h8) && (q_r.dcnt != len_of(q_r.cfg));
            2'h1: q_nxt.scl_oe = 1'b0;
            2'h2:
              if (!q_r.scl_f)
                q_nxt.ph = q_r.ph;
              else if (q_r.bitn != 4'h8)
                q_nxt.sh = {q_r.sh[6:0], q_r.sda_f};
            2'h3:
            begin
              q_nxt.scl_oe = 1'b1;
              q_nxt.bitn   = q_r.bitn + 4'h1;
              if (q_r.bitn == 4'h8)
              begin
                q_nxt.bitn                           = 4'h0;
                q_nxt.rdat[{q_r.dcnt, 3'b000} +: 8] = q_r.sh;
                if (q_r.dcnt == len_of(q_r.cfg))
                  q_nxt.st = i2c_host_pkg::ST_STOP;
                else
                  q_nxt.dcnt = q_r.dcnt + 2'h1;
              end
            end
          endcase
        end
      i2c_host_pkg::ST_STOP:
        if (tick)
        begin
          q_nxt.ph = q_r.ph + 2'h1;
          unique case (q_r.ph)
            2'h0: q_nxt.sda_oe = 1'b1;
            2'h1: q_nxt.scl_oe = 1'b0;
            2'h2:
              if (q_r.scl_f)
                q_nxt.sda_oe = 1'b0;
              else
                q_nxt.ph = q_r.ph;
            2'h3: q_nxt.st = i2c_host_pkg::ST_IDLE;
          endcase
        end
      default: q_nxt.st = i2c_host_pkg::ST_IDLE;
    endcase
  end

  // device held in reset while aresetn is low, then released with the default wait
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_r     <= '0;
      q_r.st  <= i2c_host_pkg::ST_RST;
      q_r.cnt <= 32'(`RST_LOW_CYC - 1);
      q_r.dev <= `DEV_ADDR_RST;
    end
    else
      q_r <= q_nxt;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam int EE_MIN_CYC = `EE_ADD * 4 * `QTR_1M_CYC * `EE_MARGIN_PCT / `PCT_DIV;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence rst_pulse;
    !q_r.mrst_low [*2] ##1 q_r.mrst_low;
  endsequence

  AST_RESET_PULSE: assert property ($fell(q_r.mrst_low) |-> rst_pulse)
    else $error("device reset pulse not two cycles");
  AST_READY_AFTER_WAIT: assert property ($rose(q_r.ready) |-> $past(q_r.st) == i2c_host_pkg::ST_WAIT
    && $past(q_r.cnt) == 32'h0000_0000 && q_r.mrst_low)
    else $error("ready raised before wait elapsed");
  AST_WAIT_NODEV: assert property (($rose(q_r.mrst_low) && q_r.cfg.wsel == 2'h1)
    |-> q_r.cnt == 32'(WAIT_NODEV_CYC - 1))
    else $error("wait without eeprom has wrong length");
  AST_WAIT_EE: assert property (($rose(q_r.mrst_low) && q_r.cfg.wsel[1])
    |-> q_r.cnt >= 32'(EE_MIN_CYC - 1))
    else $error("eeprom wait shorter than fixed part");
  AST_STRAP_STATIC: assert property ((!idle && $past(q_r.st) != i2c_host_pkg::ST_IDLE)
    |-> $stable(q_r.dev))
    else $error("address straps moved during transfer");
  AST_BURST_WHOLE: assert property (($rose(q_r.st == i2c_host_pkg::ST_STOP) && !q_r.nack
    && q_r.seq != i2c_host_pkg::SEQ_DEVW) |-> q_r.dcnt == len_of(q_r.cfg))
    else $error("burst stopped before last byte");
  AST_ONE_BYTE_BOUND: assert property ((q_r.st == i2c_host_pkg::ST_TX && q_r.seq == i2c_host_pkg::SEQ_DATA
    && !q_r.cfg.two_byte_offset_mode) |-> {1'b0, 8'(off_of(q_r))} + {7'h00, q_r.dcnt} <= `OFF_ONE_LAST)
    else $error("one byte burst ran past page end");
  AST_READ_RESTART: assert property ((q_r.seq == i2c_host_pkg::SEQ_DEVR
    && $past(q_r.seq) == i2c_host_pkg::SEQ_OFFL) |-> q_r.st == i2c_host_pkg::ST_START && q_r.scl_oe)
    else $error("read address not after repeated start");

endmodule
`default_nettype wire

// [dv/dev_model.sv]
// Purpose: behavioural i2c slave standing in for the timing device
// Assumes: bench resolves the open-drain lines, pull-up when released
// Notes:   page high byte is lane 1 of the four-byte page register
`timescale 1ns/100ps
`default_nettype none
module dev_model #(
  parameter int WAIT_CYC = 40
) (
  input  wire logic       aclk,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       mrst_low,
  input  wire logic [2:0] straps,
  output logic            sda_oe
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  sh, pnew;
  logic [7:0]  page = 8'h00;
  logic [15:0] ptr;
  logic [3:0]  bitc;
  logic        rd, sel;
  logic        two_b = 1'b0;
  int          nb = -1;
  int          up = 0;
  initial sda_oe = 1'b0;
  // early accesses get no answer, like a part still loading
  always @(posedge aclk) up <= mrst_low ? up + 1 : 0;
  always @(negedge sda)
    if (scl)
    begin
      nb = 0;
      bitc = 0;
    end
  always @(posedge sda) if (scl) nb = -1;
  always @(posedge scl)
    if (nb >= 0)
    begin
      if (bitc < 8) sh = {sh[6:0], sda};
      else if (rd && sda) nb = -1;
      bitc++;
    end
  always @(negedge scl)
    if (nb >= 0)
    begin
      if (bitc == 8 && nb == 0)
      begin
        // i2c port only: select and data-in pins serve as strap bits, spi wiring not modelled
        sel = sh[7:1] == {4'hb, straps} && up >= WAIT_CYC;
        rd = sh[0];
        sda_oe = sel;
        if (!sel) nb = -1;
      end
      else if (bitc == 8 && rd)
      begin
        sda_oe = 1'b0;
        ptr++;
      end
      else if (bitc == 8)
      begin
        sda_oe = 1'b1;
        if (nb == 1 && two_b) ptr[15:8] = sh;
        else if (nb == 1) ptr = {page, sh};
        else if (nb == 2 && two_b) ptr[7:0] = sh;
        else
        begin
          if (two_b ? ptr[15:2] == 14'h3fff : ptr[7:2] == 6'h3f)
          begin
            if (ptr[1:0] == 2'h1) pnew = sh;
            if (ptr[1:0] == 2'h3) page = pnew;
          end
          mem[ptr] = sh;
          ptr++;
        end
      end
      else if (bitc == 9)
      begin
        bitc = 0;
        nb++;
        sda_oe = rd ? !mem[ptr][7] : 1'b0;
      end
      else if (rd && nb > 0) sda_oe = !mem[ptr][7 - bitc];
    end
endmodule
`default_nettype wire

// [dv/tb.sv]
// Purpose: self-checking bench of the i2c host with a device model
// Assumes: wait counts shortened to 40 and 60 cycles
// Notes:   open-drain lines with pull-ups
`timescale 1ns/100ps
`default_nettype none
`include "i2c_host_map.svh"
module tb;
  logic                    aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic                    bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]              awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]             wdata = 32'h0000_0000, rdata, v;
  logic [3:0]              wstrb = 4'hf;
  logic [1:0]              bresp, rresp, rr;
  logic                    awready, wready, bvalid, arready, rvalid, dev_oe, scl_w, sda_w;
  i2c_host_pkg::link_in_t  link_i;
  i2c_host_pkg::link_out_t link_o;
  int                      num_errors = 0, checked = 0;
  time                     t0;
  assign scl_w = !(link_o.scl_oe === 1'b1);
  assign sda_w = !(link_o.sda_oe === 1'b1 || dev_oe === 1'b1);
  assign link_i = {scl_w, sda_w};
  i2c_host #(.WAIT_NOEE_CYC(40), .WAIT_NODEV_CYC(60)) DUT (.*);
  dev_model #(.WAIT_CYC(40)) u_dev (.aclk(aclk), .scl(scl_w), .sda(sda_w), .mrst_low(link_o.master_reset_low),
    .straps({link_o.bus_addr_gpio_bit2, link_o.bus_addr_strap_bit1, link_o.bus_addr_strap_bit0}), .sda_oe(dev_oe));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tk;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tk = bvalid;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tk) bready <= 1'b0;
    end
    while (!tk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ta, tk;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tk = rvalid;
      d = rdata;
      rr = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tk) rready <= 1'b0;
    end
    while (!tk);
  endtask
  // cfg is {wsel, len_m1, rate, two_byte, page, rd}; leaves STATUS in v
  task automatic go(input logic [8:0] cfg, input logic [15:0] a, input logic [31:0] d);
    wr(`REG_ADDR, {16'h0000, a});
    wr(`REG_WDATA, d);
    wr(`REG_CTRL, {21'h0_0000, cfg, 2'b01});
    do rd(`REG_STATUS, v);
    while (v[0]);
  endtask
  task automatic t_reset();
    rd(`REG_DEV, v);
    chk(v, 32'h0000_0058);
    chk({link_o.bus_addr_gpio_bit2, link_o.bus_addr_strap_bit1, link_o.bus_addr_strap_bit0}, 32'h0);
    rd(`REG_STATUS, v);
    chk(v[1], 1'b0);
    do rd(`REG_STATUS, v);
    while (!v[1]);
    rd(8'h1c, v);
    chk(rr, `RESP_SLVERR);
    $display("test reset done");
  endtask
  task automatic t_page_rates();
    go(9'h012, 16'h0000, 32'h2010_c000);
    chk(u_dev.page, 8'hc0);
    for (int r = 0; r < 3; r++)
    begin
      go({4'h0, r[1:0], 3'h0}, 16'h0024 + 16'(r), 32'h0000_00a0 + r);
      chk(u_dev.mem[16'hc024 + 16'(r)], 32'h0000_00a0 + r);
    end
    go(9'h011, 16'h0025, 32'h0000_0000);
    rd(`REG_RDATA, v);
    chk(v[7:0], 8'ha1);
    $display("test page and rates done");
  endtask
  task automatic t_two();
    u_dev.two_b = 1'b1;
    go(9'h074, 16'hcbe4, 32'h4433_2211);
    for (int i = 0; i < 4; i++) chk(u_dev.mem[16'hcbe4 + 16'(i)], 8'h11 * (i + 1));
    go(9'h075, 16'hcbe4, 32'h0000_0000);
    rd(`REG_RDATA, v);
    chk(v, 32'h4433_2211);
    go(9'h016, 16'h0000, 32'h0000_d500);
    chk(u_dev.page, 8'hd5);
    u_dev.two_b = 1'b0;
    go(9'h070, 16'h00fe, 32'h0000_0000);
    chk(v[3], 1'b1);
    wr(`REG_STATUS, 32'h0000_0008);
    $display("test two byte and refusal done");
  endtask
  task automatic t_dev();
    wr(`REG_DEV, 32'h0000_005f);
    go(9'h010, 16'h0010, 32'h0000_0077);
    chk({link_o.bus_addr_gpio_bit2, link_o.bus_addr_strap_bit1, link_o.bus_addr_strap_bit0}, 32'h7);
    chk(v[2], 1'b0);
    chk(u_dev.mem[16'hd510], 8'h77);
    wr(`REG_DEV, 32'h0000_0030);
    go(9'h010, 16'h0010, 32'h0000_0000);
    chk(v[2], 1'b1);
    wr(`REG_STATUS, 32'h0000_0004);
    t0 = $time;
    wr(`REG_CTRL, 32'h0000_0202);
    do rd(`REG_STATUS, v);
    while (!v[1]);
    chk(($time - t0) >= 600, 1'b1);
    $display("test address and reset wait done");
  endtask
  // 256 payload bytes at 1MHz: too long to wait out, so the loaded count is judged
  task automatic t_ee();
    wr(`REG_PAYLOAD, 32'h0000_0100);
    rd(`REG_PAYLOAD, v);
    chk(v, 32'h0000_0100);
    wr(`REG_CTRL, 32'h0000_0442);
    @(posedge link_o.master_reset_low);
    @(negedge aclk);
    chk(DUT.q_r.cnt, ((`EE_MUL + `EE_ADD) * 4 * `QTR_1M_CYC * `EE_MARGIN_PCT) / `PCT_DIV);
    repeat (100) @(posedge aclk);
    rd(`REG_STATUS, v);
    chk(v[1], 1'b0);
    $display("test eeprom wait done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
    forever #5 aclk = ~aclk;
  initial
  begin
    repeat (95000) @(posedge aclk);
    num_errors++;
    give_verdict();
  end
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_page_rates();
    t_two();
    t_dev();
    t_ee();
    give_verdict();
  end
endmodule
`default_nettype wire
